/* File: dv/nvc_dev_model.sv */
// Behavioural model of the nonvolatile SRAM device
`timescale 1ns/1ps
module nvc_dev_model (
	input wire logic        power_good,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic [12:0] address_in,
	input wire logic [7:0]  data_io_out,
	input wire logic        data_io_oe,
	output logic [7:0]      data_io_in
);
	logic [7:0]  mem [8192];
	logic [7:0]  nv [8192];
	logic [12:0] seq [5];
	logic [2:0]  step;
	logic        wr_act;
	logic        dirty;
	logic        busy;
	int          n_store;
	int          n_recall;
	initial begin
		seq = '{nvc_pkg::SEQ_A0, nvc_pkg::SEQ_A1, nvc_pkg::SEQ_A2,
			nvc_pkg::SEQ_A3, nvc_pkg::SEQ_A4};
		step = 3'h0;
		wr_act = 1'b0;
		dirty = 1'b0;
		busy = 1'b0;
		n_store = 0;
		n_recall = 0;
	end
	// Released lines show the inverse of the cell
	assign data_io_in = data_io_oe ? data_io_out :
		(!ce_n && !oe_n && we_n) ? mem[address_in] :
		~mem[address_in];
	always @(ce_n, we_n, address_in, data_io_out) begin
		if (!ce_n && !we_n) begin
			wr_act = 1'b1;
			if (power_good && !busy) begin
				mem[address_in] = data_io_out;
				dirty = 1'b1;
			end
		end
	end
	// Supply events: save on loss if written, recall on return
	always @(negedge power_good) begin
		if (dirty) begin
			nv = mem;
			n_store++;
			dirty = 1'b0;
		end
	end
	always @(posedge power_good) begin
		mem = nv;
		dirty = 1'b0;
	end
	always @(posedge ce_n) begin
		if (busy) begin
			step = 3'h0;
		end else if (wr_act) begin
			wr_act = 1'b0;
			step = 3'h0;
		end else if (step == 3'h5 && address_in == nvc_pkg::SEQ_STORE) begin
			if (power_good) begin
				nv = mem;
				n_store++;
				dirty = 1'b0;
				busy = 1'b1;
				busy <= #200 1'b0;
			end
			step = 3'h0;
		end else if (step == 3'h5 && address_in == nvc_pkg::SEQ_RECALL) begin
			mem = nv;
			n_recall++;
			dirty = 1'b0;
			busy = 1'b1;
			busy <= #200 1'b0;
			step = 3'h0;
		end else if (step < 3'h5 && address_in == seq[step]) begin
			step++;
		end else begin
			step = (address_in == nvc_pkg::SEQ_A0) ? 3'h1 : 3'h0;
		end
	end
endmodule

/* File: dv/nvc_host_chk.sv */
// Checker of host pin and request behaviour
`timescale 1ns/1ps
module nvc_host_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        req_valid,
	input wire logic        req_ready,
	input wire logic [1:0]  req_op,
	input wire logic        rsp_valid,
	input wire logic        power_good,
	input wire logic        ce_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic [12:0] address_in,
	input wire logic        data_io_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	addr_hold_a: assert property (
		!ce_n && !$past(ce_n) |-> $stable(address_in))
		else $error("address moved during strobe");
	addr_setup_a: assert property (
		$fell(ce_n) |-> $stable(address_in))
		else $error("address changed at strobe start");
	oe_write_a: assert property (!we_n |-> oe_n)
		else $error("output enable low in write");
	no_clash_a: assert property (!oe_n |-> !data_io_oe)
		else $error("host drives during read");
	wr_drive_a: assert property (!we_n && !ce_n |-> data_io_oe)
		else $error("write without data drive");
	pg_block_a: assert property (!power_good |-> !req_ready)
		else $error("ready while supply low");
	rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid)
		else $error("response longer than one cycle");
	rd_time_a: assert property (
		req_valid && req_ready && req_op == 2'h0 |-> ##[6:7] rsp_valid)
		else $error("read response late");
	seq_we_a: assert property (
		req_valid && req_ready && req_op[1] |=> we_n [*8])
		else $error("write strobe in sequence");
endmodule
bind nvc_host nvc_host_chk u_chk (.clock, .rst_n, .req_valid, .req_ready,
	.req_op, .rsp_valid, .power_good, .ce_n, .we_n, .oe_n, .address_in,
	.data_io_oe);

/* File: dv/nvc_host_test.sv */
// Testbench of the host controller with a device model
`timescale 1ns/1ps
module nvc_host_test;
	logic        clock, rst_n, req_valid, req_ready, rsp_valid, power_good;
	logic        ce_n, we_n, oe_n, data_io_oe;
	logic [1:0]  req_op;
	logic [12:0] req_addr, address_in;
	logic [7:0]  req_wdata, rsp_rdata, data_io_out, data_io_in, rd;
	int          mismatches, n_tests;
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	nvc_host #(.STORE_CYCLES(20), .RECALL_CYCLES(10), .RESTORE_CYCLES(10))
		u_nvc_host (.clock, .rst_n, .req_valid, .req_ready, .req_op,
		.req_addr, .req_wdata, .rsp_valid, .rsp_rdata, .power_good, .ce_n,
		.we_n, .oe_n, .address_in, .data_io_out, .data_io_oe, .data_io_in);
	nvc_dev_model u_nvc_dev_model (.power_good, .ce_n, .we_n, .oe_n,
		.address_in, .data_io_out, .data_io_oe, .data_io_in);
	task automatic check(input string what, input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run;
		if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic access(input logic [1:0] op, input logic [12:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		req_op = op;
		req_addr = a;
		req_wdata = d;
		req_valid = 1'b1;
		@(negedge clock);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		rd = rsp_rdata;
		if (n >= 300) check("response", 8'h00, 8'h01);
	endtask
	task automatic t_rw;
		access(2'h1, 13'h0123, 8'ha5);
		access(2'h1, 13'h1fff, 8'h3c);
		access(2'h0, 13'h0123, 8'h00);
		check("read 0123", rd, 8'ha5);
		access(2'h0, 13'h1fff, 8'h00);
		check("read 1fff", rd, 8'h3c);
	endtask
	task automatic t_store_recall;
		access(2'h1, 13'h0040, 8'h11);
		access(2'h2, 13'h0000, 8'h00);
		check("stores", 8'(u_nvc_dev_model.n_store), 8'h01);
		access(2'h1, 13'h0040, 8'h22);
		access(2'h0, 13'h0040, 8'h00);
		check("read new", rd, 8'h22);
		access(2'h3, 13'h0000, 8'h00);
		check("recalls", 8'(u_nvc_dev_model.n_recall), 8'h01);
		access(2'h0, 13'h0040, 8'h00);
		check("read saved", rd, 8'h11);
		access(2'h2, 13'h0000, 8'h00);
		check("stores", 8'(u_nvc_dev_model.n_store), 8'h02);
	endtask
	task automatic t_power;
		access(2'h1, 13'h0050, 8'h77);
		power_good = 1'b0;
		repeat (3) @(negedge clock);
		check("ready low", {7'h0, req_ready}, 8'h00);
		check("autosave", 8'(u_nvc_dev_model.n_store), 8'h03);
		power_good = 1'b1;
		access(2'h0, 13'h0050, 8'h00);
		check("read autosaved", rd, 8'h77);
		power_good = 1'b0;
		repeat (3) @(negedge clock);
		check("no clean save", 8'(u_nvc_dev_model.n_store), 8'h03);
		power_good = 1'b1;
		access(2'h0, 13'h0123, 8'h00);
		check("read after", rd, 8'ha5);
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		complete_run;
	end
	initial begin
		mismatches = 0;
		n_tests = 0;
		rst_n = 1'b0;
		req_valid = 1'b0;
		req_op = 2'h0;
		req_addr = 13'h0000;
		req_wdata = 8'h00;
		power_good = 1'b1;
		repeat (20) @(negedge clock);
		rst_n = 1'b1;
		t_rw;
		t_store_recall;
		t_power;
		complete_run;
	end
endmodule

/* File: hw/nvc_bus_if.sv */
// Interface between sequencer and pin cycle engine
`timescale 1ns/1ps
interface nvc_bus_if;
	logic        start;
	logic        is_write;
	logic        is_read;
	logic [12:0] addr;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        done;
	modport master (output start, is_write, is_read, addr, wdata,
		input rdata, done);
	modport engine (input start, is_write, is_read, addr, wdata,
		output rdata, done);
endinterface

/* File: hw/nvc_cycle.sv */
// Pin cycle engine: one chip-enable controlled SRAM cycle
`timescale 1ns/1ps
module nvc_cycle (
	input  wire logic  clock,
	input  wire logic  rst_n,
	nvc_bus_if.engine  bus,
	output logic       ce_n,
	output logic       we_n,
	output logic       oe_n,
	output logic [12:0] address_in,
	output logic [7:0] data_io_out,
	output logic       data_io_oe,
	input  wire logic [7:0] data_io_in
);
	typedef enum logic [1:0] {NVC_IDLE, NVC_SET, NVC_STB, NVC_HLD} nvc_cst_t;
	nvc_cst_t   st_reg;
	logic [3:0] cnt_reg;
	logic       wr_reg;
	logic       rd_reg;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= NVC_IDLE;
			cnt_reg <= 4'h0;
		end else begin
			unique case (st_reg)
				NVC_IDLE: if (bus.start) begin
					st_reg <= NVC_SET;
					cnt_reg <= 4'(nvc_pkg::CYC_SETUP - 1);
				end
				NVC_SET: if (cnt_reg == 4'h0) begin
					st_reg <= NVC_STB;
					cnt_reg <= 4'(nvc_pkg::CYC_STROBE - 1);
				end else cnt_reg <= cnt_reg - 4'h1;
				NVC_STB: if (cnt_reg == 4'h0) begin
					st_reg <= NVC_HLD;
					cnt_reg <= 4'(nvc_pkg::CYC_HOLD - 1);
				end else cnt_reg <= cnt_reg - 4'h1;
				NVC_HLD: if (cnt_reg == 4'h0) st_reg <= NVC_IDLE;
					else cnt_reg <= cnt_reg - 4'h1;
			endcase
		end
	end

	// Address, data and kind latched at start; address steady whole cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			address_in <= 13'h0000;
			data_io_out <= 8'h00;
			wr_reg <= 1'b0;
			rd_reg <= 1'b0;
		end else if (st_reg == NVC_IDLE && bus.start) begin
			address_in <= bus.addr;
			data_io_out <= bus.wdata;
			wr_reg <= bus.is_write;
			rd_reg <= bus.is_read;
		end
	end

	// Strobes: chip enable clocks the cycle, write enable high for reads
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			data_io_oe <= 1'b0;
		end else begin
			ce_n <= !(st_reg == NVC_SET && cnt_reg == 4'h0) &&
				!(st_reg == NVC_STB && cnt_reg != 4'h0);
			we_n <= !(wr_reg && (st_reg == NVC_SET || st_reg == NVC_STB) &&
				!(st_reg == NVC_STB && cnt_reg == 4'h0));
			oe_n <= !(rd_reg && (st_reg == NVC_SET || st_reg == NVC_STB) &&
				!(st_reg == NVC_STB && cnt_reg == 4'h0));
			data_io_oe <= wr_reg && st_reg != NVC_IDLE &&
				!(st_reg == NVC_HLD && cnt_reg == 4'h0);
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) bus.rdata <= 8'h00;
		else if (rd_reg && st_reg == NVC_STB && cnt_reg == 4'h0)
			bus.rdata <= data_io_in;
	end

	assign bus.done = (st_reg == NVC_HLD) && (cnt_reg == 4'h0);
endmodule

/* File: hw/nvc_host.sv */
// Host controller driving a nonvolatile SRAM over its pins
`timescale 1ns/1ps
module nvc_host #(
	parameter int STORE_CYCLES  = nvc_pkg::STORE_CYC,
	parameter int RECALL_CYCLES = nvc_pkg::RECALL_CYC,
	parameter int RESTORE_CYCLES = 13750
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        req_valid,
	output logic             req_ready,
	input  wire logic [1:0]  req_op,
	input  wire logic [12:0] req_addr,
	input  wire logic [7:0]  req_wdata,
	output logic             rsp_valid,
	output logic [7:0]       rsp_rdata,
	input  wire logic        power_good,
	output logic             ce_n,
	output logic             we_n,
	output logic             oe_n,
	output logic [12:0]      address_in,
	output logic [7:0]       data_io_out,
	output logic             data_io_oe,
	input  wire logic [7:0]  data_io_in
);
	typedef enum logic [2:0] {
		NVC_S_IDLE, NVC_S_ACC, NVC_S_SEQ, NVC_S_BUSY, NVC_S_PWR
	} nvc_state_t;

	nvc_bus_if bus ();
	nvc_state_t  state_reg;
	logic [2:0]  step_reg;
	logic        seq_store_reg;
	logic        single_write_reg;
	logic [23:0] wait_reg;

	nvc_cycle u_cycle (
		.clock       (clock),
		.rst_n       (rst_n),
		.bus         (bus),
		.ce_n        (ce_n),
		.we_n        (we_n),
		.oe_n        (oe_n),
		.address_in  (address_in),
		.data_io_out (data_io_out),
		.data_io_oe  (data_io_oe),
		.data_io_in  (data_io_in)
	);

	function automatic logic [12:0] seq_addr(input logic [2:0] step,
		input logic store);
		unique case (step)
			3'h0: seq_addr = nvc_pkg::SEQ_A0;
			3'h1: seq_addr = nvc_pkg::SEQ_A1;
			3'h2: seq_addr = nvc_pkg::SEQ_A2;
			3'h3: seq_addr = nvc_pkg::SEQ_A3;
			3'h4: seq_addr = nvc_pkg::SEQ_A4;
			default: seq_addr = store ? nvc_pkg::SEQ_STORE
				: nvc_pkg::SEQ_RECALL;
		endcase
	endfunction

	// Store and recall requests go out as a sequence of chip-enable cycles with write and output enable both high
	function automatic logic is_nv_op(input logic [1:0] op);
		is_nv_op = op == nvc_pkg::NVC_OP_STORE ||
			op == nvc_pkg::NVC_OP_RECALL;
	endfunction

	// Main sequencer state
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= NVC_S_PWR;
		end else begin
			unique case (state_reg)
				NVC_S_PWR: begin
					if (power_good && wait_reg == 24'h0) begin
						state_reg <= NVC_S_IDLE;
					end
				end
				NVC_S_IDLE: begin
					if (!power_good) begin
						state_reg <= NVC_S_PWR;
					end else if (req_valid) begin
						if (is_nv_op(req_op)) begin
							state_reg <= NVC_S_SEQ;
						end else begin
							state_reg <= NVC_S_ACC;
						end
					end
				end
				NVC_S_ACC: begin
					if (bus.done) begin
						state_reg <= NVC_S_IDLE;
					end
				end
				NVC_S_SEQ: begin
					if (bus.done && step_reg == 3'h5) begin
						state_reg <= NVC_S_BUSY;
					end
				end
				NVC_S_BUSY: begin
					if (wait_reg == 24'h0) begin
						state_reg <= NVC_S_IDLE;
					end
				end
				default: state_reg <= NVC_S_PWR;
			endcase
		end
	end

	// Power-up recall wait and store or recall busy wait
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 24'(RESTORE_CYCLES);
		end else if (state_reg == NVC_S_PWR) begin
			if (!power_good) begin
				wait_reg <= 24'(RESTORE_CYCLES);
			end else if (wait_reg != 24'h0) begin
				wait_reg <= wait_reg - 24'h1;
			end
		end else if (state_reg == NVC_S_IDLE && !power_good) begin
			wait_reg <= 24'(RESTORE_CYCLES);
		end else if (state_reg == NVC_S_SEQ && bus.done &&
			step_reg == 3'h5) begin
			wait_reg <= seq_store_reg ? 24'(STORE_CYCLES)
				: 24'(RECALL_CYCLES);
		end else if (state_reg == NVC_S_BUSY && wait_reg != 24'h0) begin
			wait_reg <= wait_reg - 24'h1;
		end
	end

	// Sequence step, advanced at the end of each chip-enable cycle except the last (step 5)
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= 3'h0;
		end else if (state_reg == NVC_S_IDLE) begin
			step_reg <= 3'h0;
		end else if (state_reg == NVC_S_SEQ && bus.done &&
			step_reg != 3'h5) begin
			step_reg <= step_reg + 3'h1;
		end
	end

	// Kind of the request taken
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_store_reg <= 1'b0;
			single_write_reg <= 1'b0;
		end else if (req_ready && req_valid) begin
			if (is_nv_op(req_op)) begin
				seq_store_reg <= req_op == nvc_pkg::NVC_OP_STORE;
			end else begin
				single_write_reg <= req_op == nvc_pkg::NVC_OP_WRITE;
			end
		end
	end

	// Cycle engine requests
	logic acc_start_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) acc_start_reg <= 1'b0;
		else acc_start_reg <= (state_reg == NVC_S_IDLE) && power_good &&
			req_valid;
	end

	logic [12:0] acc_addr_reg;
	logic [7:0]  acc_wdata_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			acc_addr_reg <= 13'h0000;
			acc_wdata_reg <= 8'h00;
		end else if (state_reg == NVC_S_IDLE && req_valid) begin
			acc_addr_reg <= req_addr;
			acc_wdata_reg <= req_wdata;
		end
	end

	logic seq_kick_reg;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) seq_kick_reg <= 1'b0;
		else seq_kick_reg <= state_reg == NVC_S_SEQ && bus.done &&
			step_reg != 3'h5;
	end

	always_comb begin
		bus.start = acc_start_reg || seq_kick_reg;
		bus.is_write = (state_reg == NVC_S_ACC) && single_write_reg;
		bus.is_read = (state_reg == NVC_S_ACC) && !single_write_reg;
		bus.addr = (state_reg == NVC_S_SEQ)
			? seq_addr(step_reg, seq_store_reg) : acc_addr_reg;
		bus.wdata = acc_wdata_reg;
	end

	assign req_ready = (state_reg == NVC_S_IDLE) && power_good;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 8'h00;
		end else begin
			rsp_valid <= (bus.done && state_reg == NVC_S_ACC) ||
				(state_reg == NVC_S_BUSY && wait_reg == 24'h0);
			if (bus.done && state_reg == NVC_S_ACC)
				rsp_rdata <= bus.rdata;
		end
	end
endmodule

/* File: hw/nvc_pkg.sv */
// Package of constants for the nonvolatile SRAM host controller
package nvc_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int CLK_MHZ = 25;
	// Cycle timing in clock cycles (40 ns each)
	localparam int CYC_SETUP = 1;
	localparam int CYC_STROBE = 2;
	localparam int CYC_HOLD = 1;
	// Software sequence addresses
	localparam logic [12:0] SEQ_A0 = 13'h0000;
	localparam logic [12:0] SEQ_A1 = 13'h1555;
	localparam logic [12:0] SEQ_A2 = 13'h0aaa;
	localparam logic [12:0] SEQ_A3 = 13'h1fff;
	localparam logic [12:0] SEQ_A4 = 13'h10f0;
	localparam logic [12:0] SEQ_STORE = 13'h0f0f;
	localparam logic [12:0] SEQ_RECALL = 13'h0f0e;
	// Busy times: store in ms, recall in us
	localparam int STORE_MS = 10;
	localparam int RECALL_US = 20;
	localparam int STORE_CYC = STORE_MS * 1000 * CLK_MHZ;
	localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
	typedef enum logic [1:0] {
		NVC_OP_READ,
		NVC_OP_WRITE,
		NVC_OP_STORE,
		NVC_OP_RECALL
	} nvc_op_t;
endpackage
